/* dscp_prio_params.svh */
// constants for the dscp priority classifier: offsets, field positions,
// reset values and timing counts
// assumes byte-wide registers at fixed byte offsets
`ifndef DSCP_PRIO_PARAMS_SVH
`define DSCP_PRIO_PARAMS_SVH

// table register offsets
`define DSCP_PRIO_CODES_0_TO_3 8'h60
`define DSCP_PRIO_CODES_4_TO_7 8'h61
`define DSCP_PRIO_CODES_8_TO_11 8'h62
`define DSCP_PRIO_CODES_12_TO_15 8'h63
`define DSCP_PRIO_CODES_28_TO_31 8'h67
`define DSCP_TBL_FIRST 8'h60
`define DSCP_TBL_LAST 8'h6F

// field layout
`define DSCP_CODE_MSB 7
`define DSCP_CODE_LSB 2
`define DSCP_CODE_W 6
`define DSCP_PRIO_W 2
`define DSCP_NUM_CODES 64
`define DSCP_TBL_BITS 128
`define DSCP_CODES_PER_REG 4
`define DSCP_NUM_REGS 16

// reset and idle values
`define DSCP_REG_RESET 8'h00
`define DSCP_PRIO_RESET 2'h0
`define DSCP_UNMAPPED_RDATA 8'h00

// timing in clock cycles
`define DSCP_LOOKUP_LATENCY 1

`endif

/* dscp_prio_pkg.sv */
// types shared by the dscp priority classifier modules
// assumes dscp_prio_params.svh is on the include path
`include "dscp_prio_params.svh"

package dscp_prio_pkg;

    typedef logic [`DSCP_PRIO_W-1:0] prio_t;
    typedef logic [`DSCP_CODE_W-1:0] dscp_code_t;
    typedef logic [`DSCP_TBL_BITS-1:0] prio_table_t;
    typedef logic [7:0] reg_byte_t;

    typedef enum logic [1:0] {
        PRIO_LOWEST = 2'b00,
        PRIO_LOW = 2'b01,
        PRIO_HIGH = 2'b10,
        PRIO_HIGHEST = 2'b11
    } prio_level_t;

endpackage : dscp_prio_pkg

/* dscp_lookup_if.sv */
// carrier between the register bank and the priority lookup stage
// assumes one clock domain shared by both ends
`timescale 1ns/10ps

interface dscp_lookup_if;
    logic tos_valid;
    dscp_prio_pkg::reg_byte_t tos_byte;
    dscp_prio_pkg::prio_table_t table_flat;
    logic prio_valid;
    dscp_prio_pkg::prio_t prio;
    dscp_prio_pkg::dscp_code_t code;

    modport bank (
        output tos_valid,
        output tos_byte,
        output table_flat,
        input prio_valid,
        input prio,
        input code
    );

    modport lookup (
        input tos_valid,
        input tos_byte,
        input table_flat,
        output prio_valid,
        output prio,
        output code
    );
endinterface : dscp_lookup_if

/* dscp_prio_lookup.sv */
// one-stage priority lookup: code from the tos byte, entry from the table
// assumes the table is stable for the cycle in which a byte is taken
`timescale 1ns/10ps
`include "dscp_prio_params.svh"

module dscp_prio_lookup (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // lookup carrier
    dscp_lookup_if.lookup lk
);

    dscp_prio_pkg::dscp_code_t code_d;
    dscp_prio_pkg::prio_t prio_d;

    // upper six bits of the byte select the entry
    assign code_d = lk.tos_byte[`DSCP_CODE_MSB:`DSCP_CODE_LSB];
    // full decode: every code has its own 2-bit pair
    assign prio_d = lk.table_flat[{code_d, 1'b0} +: `DSCP_PRIO_W];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lk.prio <= `DSCP_PRIO_RESET;
            lk.code <= '0;
        end else if (lk.tos_valid) begin
            lk.prio <= prio_d;
            lk.code <= code_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lk.prio_valid <= 1'b0;
        end else begin
            lk.prio_valid <= lk.tos_valid;
        end
    end

endmodule : dscp_prio_lookup

/* dscp_priority_classifier.sv */
// dscp priority classifier: 16 byte-wide table registers holding 64
// two-bit priorities, and the lookup that turns a tos byte into a priority
// assumes the register port and parser strobes are synchronous to clk
//
// Overview of operation
// - code is bits 7:2 of the tos or traffic-class byte.
// - six-bit code fully decoded into 64 separate two-bit table entries.
// - frame gets the two-bit value of its selected entry.
// - offset 0x60 holds codes 0x00 to 0x03, code 0x00 in bits 1:0.
// - offset 0x61 holds codes 0x04 to 0x07, ascending from bits 1:0.
// - offset 0x62 holds codes 0x08 to 0x0B, ascending from bits 1:0.
// - offset 0x63 bits 7:6 hold code 0x0F.
// - every entry is read-write and resets to 00, lowest priority.
// - offset 0x63 bits 5:0 hold codes 0x0C to 0x0E from bits 1:0.
// - packing continues; offset 0x67 holds codes 0x1C to 0x1F.
`timescale 1ns/10ps
`include "dscp_prio_params.svh"

module dscp_priority_classifier #(
    parameter int NUM_REGS = `DSCP_NUM_REGS
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register access port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_hit,
    // frame parser side
    input wire logic tos_valid,
    input wire logic [7:0] tos_byte,
    // queue selection side
    output logic prio_valid,
    output logic [1:0] prio,
    output logic [5:0] prio_code
);

    dscp_prio_pkg::reg_byte_t mem_q [NUM_REGS];
    dscp_prio_pkg::prio_table_t table_flat;
    dscp_prio_pkg::reg_byte_t rdata_q;
    dscp_prio_pkg::reg_byte_t rdata_d;
    logic rvalid_q;
    logic wr_hit;
    logic rd_hit;
    logic [3:0] wr_idx;
    logic [3:0] rd_idx;

    dscp_lookup_if lk ();

    // address inside the table window
    function automatic logic in_table(input logic [7:0] addr);
        in_table = (addr >= `DSCP_TBL_FIRST) && (addr <= `DSCP_TBL_LAST);
    endfunction : in_table

    // register index inside the table window
    function automatic logic [3:0] reg_index(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - `DSCP_TBL_FIRST;
        reg_index = diff[3:0];
    endfunction : reg_index

    // entry for one code, taken from the flat table
    function automatic dscp_prio_pkg::prio_t entry_of(
        input dscp_prio_pkg::prio_table_t tbl,
        input dscp_prio_pkg::dscp_code_t c
    );
        entry_of = tbl[{c, 1'b0} +: `DSCP_PRIO_W];
    endfunction : entry_of

    assign wr_hit = reg_wr && in_table(reg_addr);
    assign rd_hit = reg_rd && in_table(reg_addr);
    assign wr_idx = reg_index(reg_addr);
    assign rd_idx = reg_index(reg_addr);
    assign reg_hit = in_table(reg_addr);

    // table storage; writes outside the window are ignored
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                mem_q[i] <= `DSCP_REG_RESET;
            end
        end else if (wr_hit) begin
            mem_q[wr_idx] <= reg_wdata;
        end
    end

    // register n carries codes 4n..4n+3, low code in the low pair
    always_comb begin
        table_flat = '0;
        for (int i = 0; i < NUM_REGS; i++) begin
            table_flat[i*8 +: 8] = mem_q[i];
        end
    end

    // read path: unmapped offsets answer with zero
    always_comb begin
        rdata_d = `DSCP_UNMAPPED_RDATA;
        if (rd_hit) begin
            rdata_d = mem_q[rd_idx];
        end else if (reg_rd) begin
            rdata_d = `DSCP_UNMAPPED_RDATA;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= `DSCP_REG_RESET;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // a write in the same cycle as a lookup is seen by the next lookup only;
    // this keeps the lookup path free of the write data mux
    assign lk.tos_valid = tos_valid;
    assign lk.tos_byte = tos_byte;
    assign lk.table_flat = table_flat;

    dscp_prio_lookup dscp_prio_lookup_inst (
        .clk(clk),
        .arst_n(arst_n),
        .lk(lk.lookup)
    );

    assign prio_valid = lk.prio_valid;
    assign prio = lk.prio;
    assign prio_code = lk.code;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_byte_taken;
        tos_valid;
    endsequence

    sequence s_prio_shown(logic [5:0] c, logic [1:0] p);
        prio_valid && (prio_code == c) && (prio == p);
    endsequence

    sequence s_table_write(logic [7:0] a);
        reg_wr && (reg_addr == a);
    endsequence

    a_code_lookup_value: assert property (
        s_byte_taken |=> s_prio_shown(
            $past(tos_byte[7:2]),
            entry_of($past(table_flat), $past(tos_byte[7:2])))
    ) else $error("priority does not match table entry for code");

    a_prio_one_cycle: assert property (
        tos_valid |=> prio_valid
    ) else $error("priority valid not one cycle after byte valid");

    a_prio_no_spurious: assert property (
        !tos_valid |=> !prio_valid
    ) else $error("priority valid without a byte one cycle before");

    a_prio_holds_idle: assert property (
        !tos_valid |=> $stable(prio) && $stable(prio_code)
    ) else $error("priority output changed without a new byte");

    a_reg0_codes_low: assert property (
        s_table_write(`DSCP_PRIO_CODES_0_TO_3) |=>
            (entry_of(table_flat, 6'h00) == $past(reg_wdata[1:0])) &&
            (entry_of(table_flat, 6'h03) == $past(reg_wdata[7:6]))
    ) else $error("codes 0x00 to 0x03 not placed at offset 0x60");

    a_reg1_codes_order: assert property (
        s_table_write(`DSCP_PRIO_CODES_4_TO_7) |=>
            (entry_of(table_flat, 6'h04) == $past(reg_wdata[1:0])) &&
            (entry_of(table_flat, 6'h05) == $past(reg_wdata[3:2])) &&
            (entry_of(table_flat, 6'h07) == $past(reg_wdata[7:6]))
    ) else $error("codes 0x04 to 0x07 not placed at offset 0x61");

    a_reg2_codes_order: assert property (
        s_table_write(`DSCP_PRIO_CODES_8_TO_11) |=>
            (entry_of(table_flat, 6'h08) == $past(reg_wdata[1:0])) &&
            (entry_of(table_flat, 6'h0A) == $past(reg_wdata[5:4])) &&
            (entry_of(table_flat, 6'h0B) == $past(reg_wdata[7:6]))
    ) else $error("codes 0x08 to 0x0B not placed at offset 0x62");

    a_reg3_top_pair: assert property (
        s_table_write(`DSCP_PRIO_CODES_12_TO_15) |=>
            entry_of(table_flat, 6'h0F) == $past(reg_wdata[7:6])
    ) else $error("code 0x0F not in bits 7:6 of offset 0x63");

    a_reg3_low_pairs: assert property (
        s_table_write(`DSCP_PRIO_CODES_12_TO_15) |=>
            (entry_of(table_flat, 6'h0C) == $past(reg_wdata[1:0])) &&
            (entry_of(table_flat, 6'h0D) == $past(reg_wdata[3:2])) &&
            (entry_of(table_flat, 6'h0E) == $past(reg_wdata[5:4]))
    ) else $error("codes 0x0C to 0x0E not in low pairs of offset 0x63");

    a_reg7_codes_order: assert property (
        s_table_write(`DSCP_PRIO_CODES_28_TO_31) |=>
            (entry_of(table_flat, 6'h1C) == $past(reg_wdata[1:0])) &&
            (entry_of(table_flat, 6'h1F) == $past(reg_wdata[7:6]))
    ) else $error("codes 0x1C to 0x1F not placed at offset 0x67");

    a_general_packing: assert property (
        wr_hit |=> entry_of(table_flat,
            {$past(wr_idx), 2'b11}) == $past(reg_wdata[7:6])
    ) else $error("table write not at offset 0x60 plus code over four");

    a_decode_isolated: assert property (
        wr_hit |=> (table_flat & ~(128'hFF << {$past(wr_idx), 3'b000})) ==
            ($past(table_flat) & ~(128'hFF << {$past(wr_idx), 3'b000}))
    ) else $error("table write disturbed entries of other codes");

    a_reset_lowest: assert property (
        $rose(arst_n) |-> (table_flat == '0) && !prio_valid
    ) else $error("table not all lowest priority after reset");

    a_readback_value: assert property (
        rd_hit && !reg_wr |=> reg_rvalid && (reg_rdata == $past(rdata_d))
            ##0 (reg_rdata == mem_q[$past(rd_idx)])
    ) else $error("register read does not return stored table byte");

    a_unmapped_zero: assert property (
        reg_rd && !in_table(reg_addr) |=> reg_rvalid &&
            (reg_rdata == `DSCP_UNMAPPED_RDATA)
    ) else $error("unmapped read did not return zero");

    a_lookup_sees_write: assert property (
        s_table_write(`DSCP_PRIO_CODES_0_TO_3) ##1
            (tos_valid && tos_byte[7:2] == 6'h00) |=>
            prio == $past(reg_wdata[1:0], 2)
    ) else $error("lookup after a write used the old table entry");

    a_read_answer_one: assert property (
        reg_rd |=> reg_rvalid
    ) else $error("read answer not one cycle after read strobe");

    a_read_no_spurious: assert property (
        !reg_rd |=> !reg_rvalid
    ) else $error("read answer valid without a read strobe");

    a_rdata_holds: assert property (
        !reg_rd |=> $stable(reg_rdata)
    ) else $error("read data changed without a read strobe");

    a_write_lands: assert property (
        wr_hit |=> mem_q[$past(reg_addr[3:0])] == $past(reg_wdata)
    ) else $error("table byte does not hold the written value");

    a_reset_outputs: assert property (
        $rose(arst_n) |-> (reg_rdata == 8'h00) && !reg_rvalid &&
            (prio == 2'h0) && (prio_code == 6'h00)
    ) else $error("outputs not at reset values after reset release");

    // the window is one aligned block of sixteen, so the upper nibble
    // alone decides a hit
    a_hit_window: assert property (
        reg_hit == (reg_addr[7:4] == 4'h6)
    ) else $error("register hit flag disagrees with the table window");

    a_unmapped_write_kept: assert property (
        reg_wr && (reg_addr[7:4] != 4'h6) |=> $stable(table_flat)
    ) else $error("write outside the window changed the table");

    a_read_entry_map: assert property (
        rd_hit && !reg_wr |=>
            (reg_rdata[1:0] == entry_of($past(table_flat),
                {$past(reg_addr[3:0]), 2'b00})) &&
            (reg_rdata[7:6] == entry_of($past(table_flat),
                {$past(reg_addr[3:0]), 2'b11}))
    ) else $error("read byte n does not carry codes 4n to 4n+3");

    // read-after-write: the write must be visible to the very next read
    sequence s_write_then_read;
        (reg_wr && (reg_addr[7:4] == 4'h6)) ##1
            (reg_rd && !reg_wr && (reg_addr == $past(reg_addr)));
    endsequence

    a_write_read_back: assert property (
        s_write_then_read |=> reg_rvalid &&
            (reg_rdata == $past(reg_wdata, 2))
    ) else $error("read right after a write returned stale data");

    // a held byte valid must give one priority per cycle with no gap
    sequence s_two_bytes;
        tos_valid ##1 tos_valid;
    endsequence

    a_stream_lookup: assert property (
        s_two_bytes |=> prio_valid && $past(prio_valid) &&
            (prio_code == $past(tos_byte[7:2]))
    ) else $error("back-to-back bytes did not give a priority each cycle");

endmodule : dscp_priority_classifier

/* dscp_priority_classifier_tb_top.sv */
// self-checking bench for the dscp priority classifier
// assumes the design files and dscp_prio_params.svh are compiled first
`timescale 1ns/10ps
`include "dscp_prio_params.svh"

module dscp_priority_classifier_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic reg_hit;
    logic tos_valid = 1'b0;
    logic [7:0] tos_byte = 8'h00;
    logic prio_valid;
    logic [1:0] prio;
    logic [5:0] prio_code;
    int fail_count = 0;
    int num_checks = 0;
    logic [7:0] shadow [16];

    always #5 clk = ~clk;

    dscp_priority_classifier #(
        .NUM_REGS(`DSCP_NUM_REGS)
    ) dscp_priority_classifier_inst (
        .clk(clk),
        .arst_n(arst_n),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .reg_hit(reg_hit),
        .tos_valid(tos_valid),
        .tos_byte(tos_byte),
        .prio_valid(prio_valid),
        .prio(prio),
        .prio_code(prio_code)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen 0x%h expected 0x%h",
                     $time, seen, exp);
        end
    endtask : check

    // inputs move 1 ns after the edge so no race with the sampling edge
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    // strobes are left up by the access tasks so that accesses chain
    task automatic idle;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tos_valid = 1'b0;
        tick();
    endtask : idle

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_rd = 1'b0;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        if (a >= 8'h60 && a <= 8'h6F) shadow[a[3:0]] = d;
        tick();
    endtask : wr

    task automatic rd(input logic [7:0] a);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        reg_addr = a;
        tick();
    endtask : rd

    task automatic look(input logic [7:0] b);
        tos_valid = 1'b1;
        tos_byte = b;
        tick();
    endtask : look

    function automatic logic [7:0] exp_prio(input logic [5:0] c);
        return {6'h00, shadow[c[5:2]][2*c[1:0] +: 2]};
    endfunction : exp_prio

    task automatic t_reset;
        for (int i = 0; i < 16; i++) begin
            rd(8'h60 + 8'(i));
            check(reg_rdata, 8'h00);
            check({7'h00, reg_rvalid}, 8'h01);
        end
        idle();
        check({7'h00, reg_rvalid}, 8'h00);
        look(8'hFF);
        check({6'h00, prio}, 8'h00);
        idle();
        $display("test reset values done");
    endtask : t_reset

    task automatic t_rw_all;
        for (int i = 0; i < 16; i++) wr(8'h60 + 8'(i), 8'(i * 37 + 27));
        for (int i = 0; i < 16; i++) begin
            rd(8'h60 + 8'(i));
            check(reg_rdata, shadow[i]);
        end
        idle();
        $display("test read write all done");
    endtask : t_rw_all

    // entries 0..3 of one byte get priorities 0..3, lowest code in bits 1:0
    task automatic t_place(input logic [7:0] off);
        logic [5:0] base;
        base = {off[3:0], 2'b00};
        wr(off, 8'hE4);
        // no idle cycle: the first lookup must see the write just made
        reg_wr = 1'b0;
        for (int k = 0; k < 4; k++) begin
            look({base + 6'(k), 2'b10});
            check({6'h00, prio}, 8'(k));
        end
        idle();
        $display("test placement at 0x%h done", off);
    endtask : t_place

    // back-to-back stream of every code; low tos bits must be ignored
    task automatic t_scan;
        logic [5:0] cd;
        for (int c = 0; c < 64; c++) begin
            cd = 6'(c);
            look({cd, cd[1:0] ^ 2'b01});
            check({7'h00, prio_valid}, 8'h01);
            check({2'h0, prio_code}, {2'h0, cd});
            check({6'h00, prio}, exp_prio(cd));
        end
        idle();
        check({7'h00, prio_valid}, 8'h00);
        check({6'h00, prio}, exp_prio(6'h3F));
        $display("test full lookup scan done");
    endtask : t_scan

    task automatic t_unmapped;
        wr(8'h5F, 8'hFF);
        wr(8'h70, 8'hFF);
        rd(8'h5F);
        check(reg_rdata, 8'h00);
        check({7'h00, reg_hit}, 8'h00);
        rd(8'h70);
        check(reg_rdata, 8'h00);
        check({7'h00, reg_rvalid}, 8'h01);
        rd(8'h6F);
        check({7'h00, reg_hit}, 8'h01);
        check(reg_rdata, shadow[15]);
        rd(8'h60);
        check(reg_rdata, shadow[0]);
        idle();
        $display("test unmapped offsets done");
    endtask : t_unmapped

    // write, read and lookup of one entry in the same cycle see old data
    task automatic t_collide;
        logic [7:0] old;
        old = shadow[1];
        reg_wr = 1'b1;
        reg_rd = 1'b1;
        reg_addr = 8'h61;
        reg_wdata = ~old;
        tos_valid = 1'b1;
        tos_byte = {6'h04, 2'b00};
        tick();
        check(reg_rdata, old);
        check({6'h00, prio}, {6'h00, old[1:0]});
        shadow[1] = ~old;
        tos_valid = 1'b0;
        rd(8'h61);
        check(reg_rdata, ~old);
        look({6'h04, 2'b11});
        check({6'h00, prio}, exp_prio(6'h04));
        idle();
        $display("test same-cycle access done");
    endtask : t_collide

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // the whole run is well under 1000 cycles
    initial begin
        #100000;
        fail_count++;
        conclude();
    end

    initial begin
        for (int i = 0; i < 16; i++) shadow[i] = 8'h00;
        repeat (6) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_reset();
        t_rw_all();
        t_place(8'h60);
        t_place(8'h61);
        t_place(8'h62);
        t_place(8'h63);
        t_place(8'h67);
        t_scan();
        t_unmapped();
        t_collide();
        conclude();
    end
endmodule : dscp_priority_classifier_tb_top
